// [rtl/adcbc_pkg.sv]
package adcbc_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS          = 50;
   localparam int unsigned START_PULSE_MIN_NS     = 300;
   localparam int unsigned START_PULSE_MIN_CYC    =
      (START_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CONVERT_DELAY_MAX_NS   = 700;
   localparam int unsigned CONVERT_DELAY_MAX_CYC  =
      CONVERT_DELAY_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned CONVERSION_INTERVAL_NS = 10000;
   localparam int unsigned CONVERSION_INTERVAL_CYC =
      CONVERSION_INTERVAL_NS / CLK_PERIOD_NS;
   localparam int unsigned OUTPUT_ACCESS_DELAY_NS = 250;
   localparam int unsigned OUTPUT_ACCESS_DELAY_CYC =
      OUTPUT_ACCESS_DELAY_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // converter shape
   // ---------------------------------------------------------------
   localparam int unsigned SAR_BITS    = 8;
   localparam int unsigned SAR_BIT_CYC = 20;

   // ---------------------------------------------------------------
   // register map, byte addresses
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RESULT = 4'h8;
   localparam logic [3:0] REG_COUNT  = 4'hc;

   localparam int unsigned CTRL_ENABLE_BIT  = 0;
   localparam int unsigned STAT_BUSY_BIT    = 0;
   localparam int unsigned STAT_VALID_BIT   = 1;
   localparam int unsigned STAT_IGNORED_BIT = 2;
   localparam logic        CTRL_ENABLE_RST  = 1'b1;

   // synchroniser order: csN ceN rwN coding polarity comp
   localparam logic [5:0]  SYNC_RESET       = 6'h38;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic {
      ADCBC_IDLE,
      ADCBC_CONV
   } adcbc_state_e;

   typedef struct packed {
      logic csN;
      logic ceN;
      logic rwN;
   } adcbc_ctl_s;

endpackage : adcbc_pkg

// [rtl/adcbc_sync.sv]
`timescale 1ns/100ps
module adcbc_sync
   import adcbc_pkg::*;
#(
   parameter int unsigned      WIDTH     = 6,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } adcbc_sync_s;

   adcbc_sync_s s;
   adcbc_sync_s next_s;

   always_comb begin
      next_s        = s;
      next_s.stage1 = asyncIn;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{stage1: RESET_VAL, stage2: RESET_VAL};
      end else if (clkEn) begin
         s <= next_s;
      end
   end

   assign syncOut = s.stage2;

endmodule : adcbc_sync

// [rtl/adcbc_sar.sv]
`timescale 1ns/100ps
module adcbc_sar
   import adcbc_pkg::*;
#(
   parameter int unsigned BITS    = SAR_BITS,
   parameter int unsigned BIT_CYC = SAR_BIT_CYC
) (
   input  wire logic            core_clk,
   input  wire logic            rst_n,
   input  wire logic            clkEn,
   input  wire logic            start,
   input  wire logic            compHigh,
   output logic      [BITS-1:0] trialCode,
   output logic                 done
);

   localparam int unsigned IW = $clog2(BITS);
   localparam int unsigned CW = $clog2(BIT_CYC);
   localparam logic [CW-1:0] CNT_LAST = CW'(BIT_CYC - 1);
   localparam logic [IW-1:0] IDX_TOP  = IW'(BITS - 1);

   typedef struct packed {
      logic            active;
      logic [BITS-1:0] trial;
      logic [IW-1:0]   bitIdx;
      logic [CW-1:0]   cnt;
      logic            done;
   } adcbc_sar_s;

   adcbc_sar_s s;
   adcbc_sar_s next_s;

   // msb first, one decision per BIT_CYC cycles for dac settling
   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      if (start) begin
         next_s.active = 1'b1;
         next_s.trial  = '0;
         next_s.trial[IDX_TOP] = 1'b1;
         next_s.bitIdx = IDX_TOP;
         next_s.cnt    = '0;
      end else if (s.active) begin
         if (s.cnt == CNT_LAST) begin
            next_s.cnt = '0;
            if (!compHigh) begin
               next_s.trial[s.bitIdx] = 1'b0;
            end
            if (s.bitIdx == '0) begin
               next_s.active = 1'b0;
               next_s.done   = 1'b1;
            end else begin
               next_s.bitIdx = s.bitIdx - IW'(1);
               next_s.trial[s.bitIdx - IW'(1)] = 1'b1;
            end
         end else begin
            next_s.cnt = s.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (clkEn) begin
         s <= next_s;
      end
   end

   assign trialCode = s.trial;
   assign done      = s.done;

endmodule : adcbc_sar

// [rtl/adcbc_control.sv]
`timescale 1ns/100ps
module adcbc_control
   import adcbc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   input  wire adcbc_ctl_s  ctlPins,
   input  wire logic        codingSelect,
   input  wire logic        polaritySelect,
   input  wire logic        compHigh,
   output logic      [7:0]  dataOut,
   output logic             dataOeN,
   output logic             statusBusy,
   output logic      [7:0]  dacCode,
   output logic             polarityOut,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   localparam logic [3:0] START_LAST = 4'(START_PULSE_MIN_CYC - 1);
   localparam int CONV_MAX  = CONVERSION_INTERVAL_CYC;
   localparam int START_MAX = CONVERT_DELAY_MAX_CYC;

   typedef struct packed {
      adcbc_state_e state;
      logic [3:0]   startCnt;
      logic         busy;
      logic         resultValid;
      logic [7:0]   result;
      logic         codingSel;
      logic         polSel;
      logic [7:0]   dataOut;
      logic         dataOeN;
      logic         enable;
      logic         startIgnored;
      logic         prevWriteReq;
      logic         sarStart;
      logic [15:0]  convCount;
      logic         waitrequest;
      logic [31:0]  readdata;
   } adcbc_top_s;

   localparam adcbc_top_s TOP_RESET = '{
      state:       ADCBC_IDLE,
      enable:      CTRL_ENABLE_RST,
      dataOeN:     1'b1,
      waitrequest: 1'b1,
      default:     '0
   };

   adcbc_top_s s;
   adcbc_top_s next_s;

   logic [5:0] syncOut;
   logic       csNS;
   logic       ceNS;
   logic       rwNS;
   logic       codingS;
   logic       polS;
   logic       compS;
   logic [7:0] sarCode;
   logic       sarDone;
   logic       selected;
   logic       writeReq;
   logic       readReq;
   logic [31:0] regMux;

   // ---------------------------------------------------------------
   // pin synchronisers and approximation engine
   // ---------------------------------------------------------------
   adcbc_sync #(
      .WIDTH     (6),
      .RESET_VAL (SYNC_RESET)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .asyncIn  ({ctlPins.csN, ctlPins.ceN, ctlPins.rwN,
                  codingSelect, polaritySelect, compHigh}),
      .syncOut  (syncOut)
   );

   assign {csNS, ceNS, rwNS, codingS, polS, compS} = syncOut;

   adcbc_sar #(
      .BITS    (SAR_BITS),
      .BIT_CYC (SAR_BIT_CYC)
   ) u_sar (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .clkEn     (clkEn),
      .start     (s.sarStart),
      .compHigh  (compS),
      .trialCode (sarCode),
      .done      (sarDone)
   );

   // either select alone gates the decode, so they are symmetric
   assign selected = s.enable && !csNS && !ceNS;
   assign writeReq = selected && !rwNS;
   assign readReq  = selected && rwNS;

   always_comb begin
      regMux = '0;
      case (avs_address)
         REG_CTRL: begin
            regMux[CTRL_ENABLE_BIT] = s.enable;
         end
         REG_STATUS: begin
            regMux[STAT_BUSY_BIT]    = s.busy;
            regMux[STAT_VALID_BIT]   = s.resultValid;
            regMux[STAT_IGNORED_BIT] = s.startIgnored;
         end
         REG_RESULT: begin
            regMux[7:0] = s.result;
         end
         REG_COUNT: begin
            regMux[15:0] = s.convCount;
         end
         default: begin
            regMux = '0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s              = s;
      next_s.sarStart     = 1'b0;
      next_s.prevWriteReq = writeReq;

      // one wait cycle per access, readdata captured on it
      if ((avs_read || avs_write) && s.waitrequest) begin
         next_s.waitrequest = 1'b0;
         next_s.readdata    = avs_read ? regMux : '0;
      end else begin
         next_s.waitrequest = 1'b1;
      end
      if (avs_write && !s.waitrequest) begin
         if (avs_address == REG_CTRL) begin
            next_s.enable = avs_writedata[CTRL_ENABLE_BIT];
         end
         if (avs_address == REG_STATUS &&
             avs_writedata[STAT_IGNORED_BIT]) begin
            next_s.startIgnored = 1'b0;
         end
      end

      case (s.state)
         ADCBC_IDLE: begin
            // a held request restarts here after each result
            if (writeReq) begin
               if (s.startCnt == START_LAST) begin
                  next_s.state       = ADCBC_CONV;
                  next_s.busy        = 1'b1;
                  next_s.sarStart    = 1'b1;
                  next_s.resultValid = 1'b0;
                  next_s.startCnt    = '0;
                  next_s.codingSel   = codingS;
                  next_s.polSel      = polS;
               end else begin
                  next_s.startCnt = s.startCnt + 4'h1;
               end
            end else begin
               next_s.startCnt = '0;
            end
         end
         ADCBC_CONV: begin
            // placed after the bus clear so a new event wins
            if (writeReq && !s.prevWriteReq) begin
               next_s.startIgnored = 1'b1;
            end
            if (sarDone) begin
               next_s.state       = ADCBC_IDLE;
               next_s.busy        = 1'b0;
               next_s.resultValid = 1'b1;
               next_s.result      = sarCode ^ {s.codingSel, 7'h00};
               next_s.convCount   = s.convCount + 16'h0001;
            end
         end
         default: begin
            next_s.state = ADCBC_IDLE;
            next_s.busy  = 1'b0;
         end
      endcase

      // drive only for a decoded read with a finished result
      if (readReq && !s.busy && s.resultValid &&
          s.state == ADCBC_IDLE) begin
         next_s.dataOeN = 1'b0;
         next_s.dataOut = s.result;
      end else begin
         next_s.dataOeN = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= TOP_RESET;
      end else if (clkEn) begin
         s <= next_s;
      end
   end

   assign dataOut         = s.dataOut;
   assign dataOeN         = s.dataOeN;
   assign statusBusy      = s.busy;
   assign dacCode         = sarCode;
   assign polarityOut     = s.polSel;
   assign avs_readdata    = s.readdata;
   assign avs_waitrequest = s.waitrequest;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [8:0] busyCnt;
   logic [4:0] reqCnt;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busyCnt <= '0;
         reqCnt  <= '0;
      end else if (clkEn) begin
         busyCnt <= s.busy ? busyCnt + 9'h001 : 9'h000;
         reqCnt  <= (writeReq && !s.busy && s.state == ADCBC_IDLE) ?
                    reqCnt + 5'h01 : 5'h00;
      end
   end

   deselect_noop_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      (csNS || ceNS) |=> dataOeN && !$rose(statusBusy))
      else $error("deselected control caused an operation");

   start_width_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      $rose(statusBusy) |-> $past(writeReq, 1) && $past(writeReq, 2) &&
         $past(writeReq, 3) && $past(writeReq, 4) &&
         $past(writeReq, 5) && $past(writeReq, 6))
      else $error("conversion started on a short request");

   start_delay_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      reqCnt < 5'(START_MAX))
      else $error("conversion start later than allowed");

   busy_ignore_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      (statusBusy && !sarDone) |=> statusBusy && $stable(s.codingSel))
      else $error("start accepted during a conversion");

   busy_no_drive_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      statusBusy |-> dataOeN)
      else $error("data driven during a conversion");

   idle_float_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      !$past(readReq) |-> dataOeN)
      else $error("data driven without a read");

   result_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      (!dataOeN && readReq) |=> !dataOeN && $stable(dataOut))
      else $error("result dropped during a held read");

   busy_bound_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      busyCnt <= 9'(CONV_MAX))
      else $error("conversion longer than the interval");

   code_format_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      (sarDone && s.state == ADCBC_CONV) |=>
         s.result == ($past(sarCode) ^ {$past(s.codingSel), 7'h00}))
      else $error("result coding mismatch");

   restart_held_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      ($fell(statusBusy) ##1 writeReq [*6]) |=> statusBusy)
      else $error("held request did not restart");

   bus_answer_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !clkEn)
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus access not answered");

endmodule : adcbc_control

// [sim/adcbc_front_model.sv]
`timescale 1ns/100ps
// ---------------------------------------------------------------
// analog front end: comparator against a held input level
// ---------------------------------------------------------------
module adcbc_front_model
   import adcbc_pkg::*;
(
   input  wire logic [7:0] dacCode,
   input  wire logic [7:0] level,
   output logic            compHigh
);
   // ties at equal keep the bit, so the search lands on level
   assign compHigh = (level >= dacCode);
endmodule : adcbc_front_model

// [sim/tb_adc_bus_control_logic.sv]
`timescale 1ns/100ps
module tb_adc_bus_control_logic
   import adcbc_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clkEn = 1'b1;
   adcbc_ctl_s  ctlPins = '{csN: 1'b1, ceN: 1'b1, rwN: 1'b1};
   logic        codingSelect = 1'b0;
   logic        polaritySelect = 1'b0;
   logic        compHigh;
   logic [7:0]  level = 8'h00;
   logic [7:0]  dataOut;
   logic        dataOeN;
   logic        statusBusy;
   logic [7:0]  dacCode;
   logic        polarityOut;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   int          errors = 0;
   int          cmp_count = 0;
   logic [31:0] rnd = 32'd28995;
   logic [31:0] q;
   logic [31:0] cnt;
   logic [7:0]  e8;
   logic [7:0]  expQ[$];

   always #25 core_clk = ~core_clk;

   adcbc_control adcbc_control_i (
      .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
      .ctlPins(ctlPins), .codingSelect(codingSelect),
      .polaritySelect(polaritySelect), .compHigh(compHigh),
      .dataOut(dataOut), .dataOeN(dataOeN), .statusBusy(statusBusy),
      .dacCode(dacCode), .polarityOut(polarityOut),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
   );

   adcbc_front_model adcbc_front_model_i (
      .dacCode(dacCode), .level(level), .compHigh(compHigh)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xs

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, s);
         errors++;
      end
   endtask : chk

   task automatic test_done;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      // only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic pins(input logic c, input logic e, input logic r);
      @(posedge core_clk);
      ctlPins <= '{csN: c, ceN: e, rwN: r};
   endtask : pins

   task automatic idle(input int c);
      repeat (c) @(posedge core_clk);
   endtask : idle

   // which 0 watches busy, 1 watches the output enable
   task automatic waitFor(input int which, input logic v, input int lim,
                          output int k);
      k = 0;
      while (((which == 0) ? statusBusy : dataOeN) !== v && k < lim) begin
         @(posedge core_clk);
         k++;
      end
   endtask : waitFor

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic single(input logic co, input logic po,
                         input logic useCe, input logic poke);
      int k;
      rnd = xs(rnd);
      @(posedge core_clk);
      level <= rnd[7:0];
      codingSelect <= co;
      polaritySelect <= po;
      expQ.push_back(rnd[7:0] ^ {co, 7'h00});
      pins(1'b0, 1'b0, 1'b0);
      waitFor(0, 1'b1, CONVERT_DELAY_MAX_CYC, k);
      chk("busy rise", 32'h1, 32'(statusBusy));
      if (poke) begin
         pins(1'b1, 1'b0, 1'b0);
         idle(2);
         pins(1'b0, 1'b0, 1'b0);
         idle(3);
         // clock enable low must hold the approximation where it is
         clkEn <= 1'b0;
         idle(1);
         q = 32'(dacCode);
         idle(20);
         chk("frozen code", q, 32'(dacCode));
         chk("frozen busy", 32'h1, 32'(statusBusy));
         clkEn <= 1'b1;
      end
      pins(1'b0, 1'b0, 1'b1);
      k = 0;
      while (statusBusy === 1'b1 && k < CONVERSION_INTERVAL_CYC) begin
         chk("oe during busy", 32'h1, 32'(dataOeN));
         @(posedge core_clk);
         k++;
      end
      chk("conv ends", 32'h0, 32'(statusBusy));
      waitFor(1, 1'b0, OUTPUT_ACCESS_DELAY_CYC, k);
      chk("oe read", 32'h0, 32'(dataOeN));
      e8 = expQ.pop_front();
      chk("data", 32'(e8), 32'(dataOut));
      chk("polarity", 32'(po), 32'(polarityOut));
      idle(10);
      chk("data hold", 32'(e8), 32'(dataOut));
      chk("oe hold", 32'h0, 32'(dataOeN));
      bus(1'b0, REG_RESULT, 32'h0, q);
      chk("result reg", 32'(e8), q);
      if (useCe)
         pins(1'b0, 1'b1, 1'b1);
      else
         pins(1'b1, 1'b0, 1'b1);
      waitFor(1, 1'b1, 4, k);
      chk("oe float", 32'h1, 32'(dataOeN));
      pins(1'b1, 1'b1, 1'b1);
      idle(4);
   endtask : single

   task automatic continuous;
      int k;
      rnd = xs(rnd);
      bus(1'b0, REG_COUNT, 32'h0, cnt);
      @(posedge core_clk);
      level <= rnd[7:0];
      codingSelect <= 1'b1;
      polaritySelect <= 1'b0;
      pins(1'b0, 1'b0, 1'b0);
      for (int c = 0; c < 3; c++) begin
         waitFor(0, 1'b1, CONVERT_DELAY_MAX_CYC, k);
         chk("repeat start", 32'h1, 32'(statusBusy));
         // held low across two full conversions, raised while busy
         if (c == 2)
            pins(1'b0, 1'b0, 1'b1);
         waitFor(0, 1'b0, CONVERSION_INTERVAL_CYC, k);
         chk("repeat done", 32'h0, 32'(statusBusy));
         if (c < 2)
            chk("no read", 32'h1, 32'(dataOeN));
      end
      waitFor(1, 1'b0, OUTPUT_ACCESS_DELAY_CYC, k);
      chk("final data", 32'(rnd[7:0] ^ 8'h80), 32'(dataOut));
      idle(1);
      chk("no extra", 32'h0, 32'(statusBusy));
      bus(1'b0, REG_COUNT, 32'h0, q);
      chk("count", 32'((cnt + 3) & 32'hffff), q);
      pins(1'b0, 1'b0, 1'b0);
      waitFor(1, 1'b1, 4, k);
      chk("new series float", 32'h1, 32'(dataOeN));
      waitFor(0, 1'b1, CONVERT_DELAY_MAX_CYC, k);
      chk("new series", 32'h1, 32'(statusBusy));
      pins(1'b1, 1'b1, 1'b1);
      waitFor(0, 1'b0, CONVERSION_INTERVAL_CYC, k);
      idle(20);
      chk("stopped", 32'h0, 32'(statusBusy));
   endtask : continuous

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk("oe reset", 32'h1, 32'(dataOeN));
      chk("busy reset", 32'h0, 32'(statusBusy));
      bus(1'b0, REG_CTRL, 32'h0, q);
      chk("ctrl reset", 32'h1, q);
      bus(1'b0, REG_COUNT, 32'h0, q);
      chk("count reset", 32'h0, q);
      bus(1'b0, 4'h2, 32'h0, q);
      chk("unmapped", 32'h0, q);
      pins(1'b1, 1'b0, 1'b0);
      idle(20);
      chk("cs high", 32'h0, 32'(statusBusy));
      pins(1'b0, 1'b1, 1'b0);
      idle(20);
      chk("ce high", 32'h0, 32'(statusBusy));
      pins(1'b0, 1'b0, 1'b0);
      idle(2);
      pins(1'b1, 1'b1, 1'b1);
      idle(20);
      chk("short start", 32'h0, 32'(statusBusy));
      bus(1'b1, REG_CTRL, 32'h0, q);
      pins(1'b0, 1'b0, 1'b0);
      idle(20);
      chk("disabled", 32'h0, 32'(statusBusy));
      pins(1'b1, 1'b1, 1'b1);
      bus(1'b1, REG_CTRL, 32'h1, q);
      idle(4);
      for (int m = 0; m < 4; m++)
         single(m[1], m[0], m[0], m == 0);
      bus(1'b0, REG_STATUS, 32'h0, q);
      chk("ignored flag", 32'h1, 32'(q[2]));
      bus(1'b1, REG_STATUS, 32'h4, q);
      bus(1'b0, REG_STATUS, 32'h0, q);
      chk("ignored clear", 32'h0, 32'(q[2]));
      continuous();
      test_done();
   end

   initial begin
      repeat (40000) @(posedge core_clk);
      errors++;
      test_done();
   end
endmodule : tb_adc_bus_control_logic
